/* File: rtl/cophpf_defines.svh */
// Register indices, field positions, reset values and datapath constants
`ifndef COPHPF_DEFINES_SVH
`define COPHPF_DEFINES_SVH

// Register indices; the byte address is four times the index
`define COPHPF_IDX_OFS_PRIM 8'h1f
`define COPHPF_IDX_OFS_COPY 8'h20
`define COPHPF_IDX_PAT_HPF 8'h21
`define COPHPF_IDX_PAT_78 8'h23
`define COPHPF_IDX_CTRL 8'h30
`define COPHPF_IDX_STATUS 8'h31

// Writable bits of each register; reserved bits read as zero
`define COPHPF_MASK_OFS 16'h03ff
`define COPHPF_MASK_PAT_HPF 16'hffdf
`define COPHPF_MASK_PAT_78 16'h00fc
`define COPHPF_MASK_CTRL 16'h0003
`define COPHPF_RST_REG 16'h0000

// Field positions
`define COPHPF_OFS_MSB 9
`define COPHPF_PRBS_MSB 15
`define COPHPF_PRBS_LSB 12
`define COPHPF_L5_CODE_LSB 9
`define COPHPF_L6_CODE_LSB 6
`define COPHPF_L7_CODE_LSB 5
`define COPHPF_L8_CODE_LSB 2
`define COPHPF_K_MSB 4
`define COPHPF_K_LSB 1
`define COPHPF_HPF_EN_BIT 0
`define COPHPF_CTRL_OFS_EN_BIT 0
`define COPHPF_CTRL_IND_BIT 1
`define COPHPF_STAT_MISMATCH_BIT 0
`define COPHPF_STAT_HPF_ON_BIT 1

// Datapath constants
`define COPHPF_HPF_FRAC 8
`define COPHPF_PRBS_SEED 23'h7fffff
`define COPHPF_OFFSET_LANE 3

`endif

/* File: rtl/cophpf_hpf.sv */
// First-order digital high-pass filter for one channel
`default_nettype none
`include "cophpf_defines.svh"
module cophpf_hpf #(
  parameter int DATA_W = 14
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic hpf_en,
  input wire logic [3:0] corner_k,
  input wire logic in_valid,
  input wire logic signed [DATA_W-1:0] x_in,
  output var logic out_valid,
  output var logic signed [DATA_W-1:0] y_out
);
  localparam int FRAC = `COPHPF_HPF_FRAC;
  localparam int W = DATA_W + FRAC + 3;
  localparam logic signed [W-1:0] Y_MAX = W'((2 ** (DATA_W - 1)) - 1);
  localparam logic signed [W-1:0] Y_MIN = -W'(2 ** (DATA_W - 1));

  logic signed [DATA_W-1:0] x1_q;
  logic signed [W-1:0] y1_q;
  logic signed [W-1:0] sum;
  logic signed [W-1:0] filt;
  logic signed [W-1:0] whole;
  logic [5:0] k2;
  logic [5:0] k3;

  // Gain 2^k/(2^k+1) as 1 - 2^-k + 2^-2k - 2^-3k, fraction kept in state
  always_comb
  begin
    k2 = {1'b0, corner_k, 1'b0};
    k3 = k2 + {2'b00, corner_k};
    sum = (W'(x_in) <<< FRAC) - (W'(x1_q) <<< FRAC) + y1_q;
    filt = sum - (sum >>> corner_k) + (sum >>> k2) - (sum >>> k3);
    whole = filt >>> FRAC;
  end

  // Sample history and saturated output
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      x1_q <= '0;
      y1_q <= '0;
      y_out <= '0;
      out_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      out_valid <= in_valid;
      if (in_valid)
      begin
        x1_q <= x_in;
        if (hpf_en)
        begin
          y1_q <= filt;
          if (whole > Y_MAX)
            y_out <= Y_MAX[DATA_W-1:0];
          else if (whole < Y_MIN)
            y_out <= Y_MIN[DATA_W-1:0];
          else
            y_out <= whole[DATA_W-1:0];
        end
        else
        begin
          y1_q <= '0;
          y_out <= x_in;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_hpf_bypass: assert property (
    clk_en && in_valid && !hpf_en |=> y_out == $past(x_in) && out_valid)
    else $error("filter off but sample not passed through");

  a_hpf_dc_block: assert property (
    clk_en && in_valid && hpf_en && x_in == x1_q && y1_q == '0 |=> y_out == '0)
    else $error("filter passed a steady input");
endmodule // cophpf_hpf
`default_nettype wire

/* File: rtl/cophpf_pkg.sv */
// Types shared by the offset, pattern and high-pass block
`default_nettype none
package cophpf_pkg;
  // Per-lane test pattern codes; other codes pass sample data
  typedef enum logic [2:0] {
    COPHPF_PAT_NORMAL = 3'b000,
    COPHPF_PAT_ZEROS = 3'b001,
    COPHPF_PAT_ONES = 3'b010,
    COPHPF_PAT_TOGGLE = 3'b011,
    COPHPF_PAT_RAMP = 3'b100
  } cophpf_pat_t;

  typedef logic [15:0] cophpf_reg_t;
endpackage
`default_nettype wire

/* File: rtl/cophpf_top.sv */
// Offset on lane 8, test pattern and high-pass post-processing for lanes 5 to 8
`default_nettype none
`include "cophpf_defines.svh"
module cophpf_top
  import cophpf_pkg::*;
#(
  parameter int DATA_W = 14,
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic pready,
  output var logic [31:0] prdata,
  output var logic pslverr,
  input wire logic sample_valid,
  input wire logic [3:0][DATA_W-1:0] sample_ch,
  output var logic lane_valid,
  output var logic [3:0][DATA_W-1:0] lane_data
);
  localparam logic signed [DATA_W:0] S_MAX = (DATA_W+1)'((2 ** (DATA_W - 1)) - 1);
  localparam logic signed [DATA_W:0] S_MIN = -(DATA_W+1)'(2 ** (DATA_W - 1));

  logic [9:0] ofs_prim_q;
  logic [9:0] ofs_copy_q;
  cophpf_reg_t pat_hpf_q;
  cophpf_reg_t pat78_q;
  logic [1:0] ctrl_q;
  logic mismatch_q;
  logic [22:0] lfsr_q;
  logic [DATA_W-1:0] ramp_q;
  logic toggle_q;
  logic [3:0] hpf_valid;
  logic [3:0][DATA_W-1:0] hpf_y;
  logic access;
  logic commit_wr;
  logic [7:0] idx;
  logic [15:0] rd_val;
  logic [3:0][DATA_W-1:0] lane_d;

  // Only these indices answer without error
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] i;
    i = addr[9:2];
    is_mapped = (addr[ADDR_W-1:10] == '0) && (addr[1:0] == 2'b00) &&
      (i == `COPHPF_IDX_OFS_PRIM || i == `COPHPF_IDX_OFS_COPY ||
       i == `COPHPF_IDX_PAT_HPF || i == `COPHPF_IDX_PAT_78 ||
       i == `COPHPF_IDX_CTRL || i == `COPHPF_IDX_STATUS);
  endfunction

  // Pattern code of one lane (0 is lane 5)
  function automatic logic [2:0] lane_code(input int lane, input cophpf_reg_t ph,
                                           input cophpf_reg_t p78);
    logic [2:0] c;
    c = 3'h0;
    case (lane)
      0: c = ph[`COPHPF_L5_CODE_LSB +: 3];
      1: c = ph[`COPHPF_L6_CODE_LSB +: 3];
      2: c = p78[`COPHPF_L7_CODE_LSB +: 3];
      default: c = p78[`COPHPF_L8_CODE_LSB +: 3];
    endcase
    lane_code = c;
  endfunction

  // Signed sample plus sign-extended offset, saturated
  function automatic logic [DATA_W-1:0] sat_add(input logic [DATA_W-1:0] s,
                                                 input logic [9:0] o);
    logic signed [DATA_W:0] t;
    t = $signed({s[DATA_W-1], s}) + (DATA_W+1)'($signed(o));
    if (t > S_MAX)
      sat_add = S_MAX[DATA_W-1:0];
    else if (t < S_MIN)
      sat_add = S_MIN[DATA_W-1:0];
    else
      sat_add = t[DATA_W-1:0];
  endfunction

  // APB decode
  assign access = psel && penable;
  assign commit_wr = access && pready && pwrite && clk_en;
  assign idx = paddr[9:2];

  // APB answer one cycle into the access phase
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= access && !pready;
      if (access && !pready)
      begin
        pslverr <= !is_mapped(paddr);
        prdata <= (!pwrite && is_mapped(paddr)) ? {16'h0000, rd_val} : 32'h0000_0000;
      end
    end
  end

  // Read multiplexer
  always_comb
  begin
    rd_val = 16'h0000;
    case (idx)
      `COPHPF_IDX_OFS_PRIM: rd_val = {6'h00, ofs_prim_q};
      `COPHPF_IDX_OFS_COPY: rd_val = {6'h00, ofs_copy_q};
      `COPHPF_IDX_PAT_HPF: rd_val = pat_hpf_q;
      `COPHPF_IDX_PAT_78: rd_val = pat78_q;
      `COPHPF_IDX_CTRL: rd_val = {14'h0000, ctrl_q};
      `COPHPF_IDX_STATUS: rd_val = {14'h0000, pat_hpf_q[`COPHPF_HPF_EN_BIT], mismatch_q};
      default: rd_val = 16'h0000;
    endcase
  end

  // Register file; only defined bits are stored
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ofs_prim_q <= '0;
      ofs_copy_q <= '0;
      pat_hpf_q <= `COPHPF_RST_REG;
      pat78_q <= `COPHPF_RST_REG;
      ctrl_q <= '0;
    end
    else if (commit_wr && paddr[ADDR_W-1:10] == '0 && paddr[1:0] == 2'b00)
    begin
      case (idx)
        `COPHPF_IDX_OFS_PRIM: ofs_prim_q <= pwdata[`COPHPF_OFS_MSB:0];
        `COPHPF_IDX_OFS_COPY: ofs_copy_q <= pwdata[`COPHPF_OFS_MSB:0];
        `COPHPF_IDX_PAT_HPF: pat_hpf_q <= pwdata[15:0] & `COPHPF_MASK_PAT_HPF;
        `COPHPF_IDX_PAT_78: pat78_q <= pwdata[15:0] & `COPHPF_MASK_PAT_78;
        `COPHPF_IDX_CTRL: ctrl_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Flags when the two offset copies disagree
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mismatch_q <= 1'b0;
    else if (clk_en)
      mismatch_q <= ofs_prim_q != ofs_copy_q;
  end

  // High-pass filter with shared settings, one instance per channel
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_hpf
      cophpf_hpf #(
        .DATA_W(DATA_W)
      ) cophpf_hpf_i (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .hpf_en(pat_hpf_q[`COPHPF_HPF_EN_BIT]),
        .corner_k(pat_hpf_q[`COPHPF_K_MSB:`COPHPF_K_LSB]),
        .in_valid(sample_valid),
        .x_in(sample_ch[g]),
        .out_valid(hpf_valid[g]),
        .y_out(hpf_y[g])
      );
    end
  endgenerate

  // Pattern sources step once per sample
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      lfsr_q <= `COPHPF_PRBS_SEED;
      ramp_q <= '0;
      toggle_q <= 1'b0;
    end
    else if (clk_en && hpf_valid[0])
    begin
      lfsr_q <= {lfsr_q[21:0], lfsr_q[22] ^ lfsr_q[17]};
      ramp_q <= ramp_q + 1'b1;
      toggle_q <= !toggle_q;
    end
  end

  // Per-lane choice of offset data, PRBS or fixed pattern
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (i == `COPHPF_OFFSET_LANE && ctrl_q[`COPHPF_CTRL_OFS_EN_BIT])
        lane_d[i] = sat_add(hpf_y[i], ofs_copy_q);
      else
        lane_d[i] = hpf_y[i];
      if (ctrl_q[`COPHPF_CTRL_IND_BIT])
      begin
        if (pat_hpf_q[`COPHPF_PRBS_MSB - i])
          lane_d[i] = lfsr_q[DATA_W-1:0];
        else
        begin
          case (lane_code(i, pat_hpf_q, pat78_q))
            COPHPF_PAT_ZEROS: lane_d[i] = '0;
            COPHPF_PAT_ONES: lane_d[i] = '1;
            COPHPF_PAT_TOGGLE: lane_d[i] = toggle_q ? {(DATA_W/2){2'b10}} :
                                                      {(DATA_W/2){2'b01}};
            COPHPF_PAT_RAMP: lane_d[i] = ramp_q;
            default: ;
          endcase
        end
      end
    end
  end

  // Output lanes
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      lane_valid <= 1'b0;
      lane_data <= '0;
    end
    else if (clk_en)
    begin
      lane_valid <= hpf_valid[0];
      if (hpf_valid[0])
        lane_data <= lane_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_apb_answer_time: assert property (
    clk_en && access && !pready |=> pready)
    else $error("apb answer late");

  a_apb_single_ready: assert property (
    clk_en && pready |=> !pready)
    else $error("apb ready held too long");

  a_apb_unmapped_err: assert property (
    clk_en && access && !pready && !is_mapped(paddr) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_hpf_enable_write: assert property (
    commit_wr && paddr == ADDR_W'({`COPHPF_IDX_PAT_HPF, 2'b00})
    |=> pat_hpf_q[`COPHPF_HPF_EN_BIT] == $past(pwdata[0]))
    else $error("filter enable not taken from write");

  a_offset_apply: assert property (
    clk_en && hpf_valid[3] && !ctrl_q[`COPHPF_CTRL_IND_BIT]
    |=> lane_data[3] == ($past(ctrl_q[0]) ? sat_add($past(hpf_y[3]), $past(ofs_copy_q))
                                          : $past(hpf_y[3])))
    else $error("offset lane wrong");

  a_offset_mismatch: assert property (
    clk_en && ofs_prim_q != ofs_copy_q |=> mismatch_q)
    else $error("offset copy mismatch not flagged");

  a_lane_valid_lag: assert property (
    clk_en && hpf_valid[0] |=> lane_valid ##1 (!clk_en || hpf_valid[0] || !lane_valid))
    else $error("lane valid timing wrong");

  generate
    for (g = 0; g < 4; g++)
    begin : g_chk
      a_prbs_lane_out: assert property (
        clk_en && hpf_valid[0] && ctrl_q[1] && pat_hpf_q[15 - g]
        |=> lane_data[g] == $past(lfsr_q[DATA_W-1:0]))
        else $error("prbs lane wrong");

      a_pattern_fixed: assert property (
        clk_en && hpf_valid[0] && ctrl_q[1] && !pat_hpf_q[15 - g] &&
        lane_code(g, pat_hpf_q, pat78_q) inside {COPHPF_PAT_ZEROS, COPHPF_PAT_ONES}
        |=> lane_data[g] == ($past(lane_code(g, pat_hpf_q, pat78_q)) == COPHPF_PAT_ONES
                             ? {DATA_W{1'b1}} : {DATA_W{1'b0}}))
        else $error("fixed pattern lane wrong");

      a_pattern_ramp: assert property (
        clk_en && hpf_valid[0] && ctrl_q[1] && !pat_hpf_q[15 - g] &&
        lane_code(g, pat_hpf_q, pat78_q) == COPHPF_PAT_RAMP
        |=> lane_data[g] == $past(ramp_q))
        else $error("ramp pattern lane wrong");
    end
  endgenerate
endmodule // cophpf_top
`default_nettype wire

/* File: testbench/cophpf_rx_model.sv */
// Receiving logic model that captures each set of lane words
`default_nettype none
module cophpf_rx_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic lane_valid,
  input wire logic [3:0][13:0] lane_data,
  output var logic [3:0][13:0] rx_word,
  output var int rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Capture the lane words on each valid pulse, count the sets
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rx_count <= 0;
      rx_word <= '0;
    end
    else if (lane_valid)
    begin
      rx_count <= rx_count + 1;
      rx_word <= lane_data;
    end
  end
endmodule // cophpf_rx_model
`default_nettype wire

/* File: testbench/cophpf_top_tb.sv */
// Self-checking bench for the offset, pattern and high-pass block
`default_nettype none
`include "cophpf_defines.svh"
module cophpf_top_tb;
  import cophpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sample_valid = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0][13:0] sample_ch = '0;
  logic pready, pslverr, lane_valid;
  logic [31:0] prdata;
  logic [3:0][13:0] lane_data, rx_word;
  logic [13:0] w0;
  int rx_count;
  int n0;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  // Clock and design under test with receiver
  always #20 core_clk = ~core_clk;
  cophpf_top cophpf_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_ch(sample_ch), .lane_valid(lane_valid), .lane_data(lane_data));
  cophpf_rx_model cophpf_rx_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .lane_valid(lane_valid), .lane_data(lane_data), .rx_word(rx_word), .rx_count(rx_count));

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      summarize();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic near(input logic [13:0] v, input int e, input int t);
    int d;
    if ($isunknown(v))
      return 1'b0;
    d = int'($signed(v)) - e;
    return d <= t && d >= -t;
  endfunction

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] wd,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 16'h0000, r, e);
    check({r, 31'h0, e}, {exp, 31'h0, ee});
  endtask

  // One sample set in, wait for the receiver to capture its result
  task automatic smp(input logic [13:0] a, input logic [13:0] b, input logic [13:0] c,
    input logic [13:0] d);
    int c0;
    c0 = rx_count;
    sample_ch <= {d, c, b, a};
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    while (rx_count == c0)
      @(posedge core_clk);
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rdc(`COPHPF_IDX_PAT_HPF, 32'h0, 1'b0);
    rdc(`COPHPF_IDX_OFS_COPY, 32'h0, 1'b0);
    wr(`COPHPF_IDX_PAT_HPF, 16'hf3d4);
    rdc(`COPHPF_IDX_PAT_HPF, 32'hf3d4, 1'b0);
    rdc(8'h05, 32'h0, 1'b1);
    wr(`COPHPF_IDX_PAT_HPF, 16'h0000);
    wr(`COPHPF_IDX_OFS_PRIM, 16'h0200);
    wr(`COPHPF_IDX_OFS_COPY, 16'h0200);
    smp(14'd100, 14'd200, 14'd300, 14'd1000);
    check(rx_word, {14'd1000, 14'd300, 14'd200, 14'd100});
    wr(`COPHPF_IDX_CTRL, 16'h0001);
    smp(14'd100, 14'd200, 14'd300, 14'd1000);
    check(rx_word, {14'd488, 14'd300, 14'd200, 14'd100});
    wr(`COPHPF_IDX_OFS_PRIM, 16'h01ff);
    rdc(`COPHPF_IDX_STATUS, 32'h1, 1'b0);
    wr(`COPHPF_IDX_OFS_COPY, 16'h01ff);
    smp(14'd100, 14'd200, 14'd300, 14'd1000);
    check(rx_word, {14'd1511, 14'd300, 14'd200, 14'd100});
    // Patterns: ignored without independent select, then PRBS, then codes
    wr(`COPHPF_IDX_CTRL, 16'h0000);
    wr(`COPHPF_IDX_PAT_78, 16'h0020);
    wr(`COPHPF_IDX_PAT_HPF, 16'hf440);
    smp(14'd11, 14'd22, 14'd33, 14'd44);
    check(rx_word, {14'd44, 14'd33, 14'd22, 14'd11});
    wr(`COPHPF_IDX_CTRL, 16'h0002);
    rdc(`COPHPF_IDX_CTRL, 32'h2, 1'b0);
    // All-ones seed stepped by four earlier samples, same word on every lane
    smp(14'd11, 14'd22, 14'd33, 14'd44);
    check(rx_word, {4{14'h3ff0}});
    smp(14'd11, 14'd22, 14'd33, 14'd44);
    check(rx_word, {4{14'h3fe0}});
    wr(`COPHPF_IDX_PAT_HPF, 16'h0440);
    smp(14'd11, 14'd22, 14'd33, 14'd44);
    check(rx_word, {14'd44, 14'h0000, 14'h0000, 14'h3fff});
    // Toggle on lane 5, data on lane 6, zeros on lane 7, ramp on lane 8
    wr(`COPHPF_IDX_PAT_78, 16'h0030);
    rdc(`COPHPF_IDX_PAT_78, 32'h30, 1'b0);
    wr(`COPHPF_IDX_PAT_HPF, 16'h0600);
    smp(14'd11, 14'd22, 14'd33, 14'd44);
    w0 = rx_word[0];
    smp(14'd11, 14'd22, 14'd33, 14'd44);
    check({w0 ^ rx_word[0], w0 == 14'h2aaa || w0 == 14'h1555}, {14'h3fff, 1'b1});
    check(rx_word[3:1], {14'd8, 14'h0000, 14'd22});
    // High-pass: step response, decay, new corner, then bypass
    wr(`COPHPF_IDX_PAT_78, 16'h0000);
    wr(`COPHPF_IDX_PAT_HPF, 16'h0000);
    smp(14'd0, 14'd0, 14'd0, 14'd0);
    wr(`COPHPF_IDX_PAT_HPF, 16'h0005);
    rdc(`COPHPF_IDX_STATUS, 32'h2, 1'b0);
    smp(14'd0, 14'd0, 14'd0, 14'd0);
    check(rx_word, '0);
    smp(14'd1000, 14'd1000, 14'd1000, 14'd1000);
    check({near(rx_word[0], 800, 8), rx_word[3] == rx_word[0]}, 2'b11);
    repeat (40) smp(14'd1000, 14'd1000, 14'd1000, 14'd1000);
    check(near(rx_word[2], 0, 4), 1'b1);
    wr(`COPHPF_IDX_PAT_HPF, 16'h0015);
    smp(14'd0, 14'd0, 14'd0, 14'd0);
    check(near(rx_word[1], -999, 8), 1'b1);
    wr(`COPHPF_IDX_PAT_HPF, 16'h0014);
    smp(14'd1234, 14'd1234, 14'd1234, 14'd1234);
    check(rx_word, {4{14'd1234}});
    // Clock enable low: a held sample is not taken
    n0 = rx_count;
    clk_en <= 1'b0;
    sample_valid <= 1'b1;
    repeat (3) @(posedge core_clk);
    sample_valid <= 1'b0;
    clk_en <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(rx_count, n0);
    summarize();
  end
endmodule // cophpf_top_tb
`default_nettype wire
